/* design/eia_extended_instruction_alu.sv */
/*
  extended-instruction alu: condition test, alu with constant operands,
  pass, multifunction transfers, context switch, global interrupt gate,
  slow low-power wait with divided core clock enable.
  assumes a sequencer outside feeds one decoded word per cycle while
  core_clk_en_o is high, and drops an interrupt request once taken.
*/
`timescale 1ns/100ps
module eia_extended_instruction_alu #(
  parameter int unsigned NIRQ = 8
) (
  // clock, reset, enable
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  // instruction
  input  wire logic              op_valid_i,
  input  wire logic [23:0]       instr_i,
  // memory data and other units
  input  wire logic [15:0]       mem_rd0_i,
  input  wire logic [15:0]       mem_rd1_i,
  input  wire logic [15:0]       mac_result_low_i,
  input  wire logic [15:0]       mac_result_mid_i,
  input  wire logic [15:0]       mac_result_high_i,
  input  wire logic [15:0]       shifter_result_low_i,
  input  wire logic [15:0]       shifter_result_high_i,
  input  wire logic              mac_ovf_i,
  input  wire logic              cntr_expired_i,
  // interrupts and autobuffer
  input  wire logic [NIRQ-1:0]   irq_req_i,
  input  wire logic              autobuf_req_i,
  // results
  output logic [15:0]            alu_result_reg_o,
  output logic [15:0]            alu_feedback_reg_o,
  output logic [3:0]             flags_o,
  output logic                   branch_o,
  output logic                   mem_wr_o,
  output logic [15:0]            mem_wr_data_o,
  output logic                   illegal_o,
  // sequencing and interrupts
  output logic                   irq_take_o,
  output logic [NIRQ-1:0]        irq_sel_o,
  output logic                   idle_o,
  output logic                   core_clk_en_o,
  output logic                   ctx_o,
  output logic                   gie_o,
  output logic [NIRQ-1:0]        interrupt_mask_reg_o,
  output logic                   autobuf_grant_o
);

  // sixteen condition codes over alu flags and outside status
  function automatic logic cond_true(input logic [3:0] c,
                                     input logic [3:0] f,
                                     input logic mv, input logic ce);
    logic lt;
    lt = f[eia_pkg::FL_AN] ^ f[eia_pkg::FL_AV];
    case (c)
      4'h0: cond_true = f[eia_pkg::FL_AZ];
      4'h1: cond_true = !f[eia_pkg::FL_AZ];
      4'h2: cond_true = !lt && !f[eia_pkg::FL_AZ];
      4'h3: cond_true = lt || f[eia_pkg::FL_AZ];
      4'h4: cond_true = lt;
      4'h5: cond_true = !lt;
      4'h6: cond_true = f[eia_pkg::FL_AV];
      4'h7: cond_true = !f[eia_pkg::FL_AV];
      4'h8: cond_true = f[eia_pkg::FL_AC];
      4'h9: cond_true = !f[eia_pkg::FL_AC];
      4'ha: cond_true = f[eia_pkg::FL_AN];
      4'hb: cond_true = !f[eia_pkg::FL_AN];
      4'hc: cond_true = mv;
      4'hd: cond_true = !mv;
      4'he: cond_true = !ce;
      default: cond_true = 1'b1;
    endcase
  endfunction

  // 0, 2^0..2^14, 32767, -(2^k+1) k=0..14, -32768; 33 codes need 6 bits
  function automatic logic [15:0] alu_const(input logic [5:0] i);
    if (i == 6'h00) alu_const = 16'h0000;
    else if (i <= 6'h0f) alu_const = 16'h0001 << (i - 6'h01);
    else if (i == 6'h10) alu_const = 16'h7fff;
    else if (i <= 6'h1f) alu_const = ~(16'h0001 << (i - 6'h11));
    else alu_const = 16'h8000;
  endfunction

  // 0, then 2^k-1, 2^k, 2^k+1 for k = 1..15
  function automatic logic [15:0] pass_const(input logic [5:0] i);
    int unsigned j;
    j = 32'(i) - 1;
    if (i == 6'h00) pass_const = 16'h0000;
    else pass_const = 16'((32'd1 << (j / 3 + 1)) - 1 + (j % 3));
  endfunction

  // returns {carry, overflow, result}
  function automatic logic [17:0] alu_fn(input eia_pkg::eia_func_t fn,
                                         input logic [15:0] x,
                                         input logic [15:0] y,
                                         input logic ci);
    logic [15:0] a;
    logic [15:0] b;
    logic        cin;
    logic [16:0] s;
    a = x;
    b = y;
    cin = 1'b0;
    case (fn)
      eia_pkg::F_ADDC:   cin = ci;
      eia_pkg::F_XSUBY:  begin b = ~y; cin = 1'b1; end
      eia_pkg::F_XSUBYB: begin b = ~y; cin = ci; end
      eia_pkg::F_YSUBX:  begin a = y; b = ~x; cin = 1'b1; end
      eia_pkg::F_YSUBXB: begin a = y; b = ~x; cin = ci; end
      default: ;
    endcase
    s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    case (fn)
      eia_pkg::F_AND: alu_fn = {2'b00, x & y};
      eia_pkg::F_OR:  alu_fn = {2'b00, x | y};
      eia_pkg::F_XOR: alu_fn = {2'b00, x ^ y};
      default: alu_fn = {s[16], (a[15] == b[15]) && (s[15] != a[15]),
                         s[15:0]};
    endcase
  endfunction

  // state
  logic [15:0]          rf_r   [2][eia_pkg::RF_N];
  logic [15:0]          rf_nxt [2][eia_pkg::RF_N];
  logic [3:0]           flg_r, flg_nxt;
  logic                 ctx_r, ctx_nxt;
  logic                 gie_r, gie_nxt;
  logic [NIRQ-1:0]      mask_r, mask_nxt;
  eia_pkg::eia_state_t  st_r, st_nxt;
  logic [6:0]           cnt_r, cnt_nxt;
  logic [6:0]           lim_r, lim_nxt;
  logic                 br_r, br_nxt;
  logic                 wr_r, wr_nxt;
  logic [15:0]          wd_r, wd_nxt;
  logic                 ill_r, ill_nxt;
  logic                 take_r, take_nxt;
  logic [NIRQ-1:0]      sel_r, sel_nxt;
  logic                 cke_r, cke_nxt;
  logic                 ab_r, ab_nxt;
  logic [15:0]          ar_r, ar_nxt;
  logic [15:0]          af_r, af_nxt;

  // decode and execute
  eia_pkg::eia_op_t     op;
  eia_pkg::eia_func_t   fn;
  logic [3:0]           cnd;
  logic [2:0]           xs;
  logic [1:0]           ys;
  logic [5:0]           ci;
  logic [NIRQ-1:0]      svc;
  logic [NIRQ-1:0]      pick;
  logic [15:0]          xv, yv, res;
  logic [17:0]          fr;
  logic                 go;
  logic [2:0]           dc;

  always_comb begin
    op  = eia_pkg::eia_op_t'(instr_i[eia_pkg::OP_LSB +: 4]);
    fn  = eia_pkg::eia_func_t'(instr_i[eia_pkg::FUNC_LSB +: 4]);
    cnd = instr_i[eia_pkg::COND_LSB +: 4];
    xs  = instr_i[eia_pkg::XOP_LSB +: 3];
    ys  = instr_i[eia_pkg::YOP_LSB +: 2];
    ci  = instr_i[eia_pkg::CONST_LSB +: 6];
    dc  = instr_i[eia_pkg::DIV_LSB +: 3];
    // global enable gates every masked request; mask is untouched
    svc = irq_req_i & mask_r & {NIRQ{gie_r}};
    pick = '0;
    for (int n = 0; n < NIRQ; n++) begin
      if (svc[n]) pick = '0;
      if (svc[n]) pick[n] = 1'b1; // highest index wins
    end
    case (xs)
      eia_pkg::X_AX0: xv = rf_r[ctx_r][eia_pkg::RF_AX0];
      eia_pkg::X_AX1: xv = rf_r[ctx_r][eia_pkg::RF_AX1];
      eia_pkg::X_AR:  xv = rf_r[ctx_r][eia_pkg::RF_AR];
      eia_pkg::X_MR0: xv = mac_result_low_i;
      eia_pkg::X_MR1: xv = mac_result_mid_i;
      eia_pkg::X_MR2: xv = mac_result_high_i;
      eia_pkg::X_SR0: xv = shifter_result_low_i;
      default:        xv = shifter_result_high_i;
    endcase
    case (ys)
      eia_pkg::Y_AY0: yv = rf_r[ctx_r][eia_pkg::RF_AY0];
      eia_pkg::Y_AY1: yv = rf_r[ctx_r][eia_pkg::RF_AY1];
      eia_pkg::Y_AF:  yv = rf_r[ctx_r][eia_pkg::RF_AF];
      default: yv = (op == eia_pkg::EIA_PASS)
                    ? pass_const(ci) : alu_const(ci);
    endcase
    fr = alu_fn(fn, xv, yv, flg_r[eia_pkg::FL_AC]);
    res = fr[15:0];
    go = cond_true(cnd, flg_r, mac_ovf_i, cntr_expired_i);
    rf_nxt = rf_r;
    flg_nxt = flg_r;
    ctx_nxt = ctx_r;
    gie_nxt = gie_r;
    mask_nxt = mask_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    lim_nxt = lim_r;
    br_nxt = 1'b0;
    wr_nxt = 1'b0;
    wd_nxt = wd_r;
    ill_nxt = 1'b0;
    take_nxt = 1'b0;
    sel_nxt = sel_r;
    cke_nxt = 1'b1;
    // autobuffer service is never gated by the global enable
    ab_nxt = autobuf_req_i;
    case (st_r)
      eia_pkg::ST_RUN: begin
        if (|svc) begin
          take_nxt = 1'b1;
          sel_nxt = pick;
        end
        if (op_valid_i) begin
          case (op)
            eia_pkg::EIA_ALU: begin
              // a refused word must leave registers and flags alone
              ill_nxt = (fn > eia_pkg::F_XOR) ||
                        (ys == eia_pkg::Y_CONST && ci > 6'h20);
              if (go && !ill_nxt) begin
                rf_nxt[ctx_r][instr_i[eia_pkg::DEST_BIT]
                              ? eia_pkg::RF_AF : eia_pkg::RF_AR] = res;
                flg_nxt = {fr[16], fr[17], res[15], res == 16'h0000};
              end
            end
            eia_pkg::EIA_PASS: begin
              ill_nxt = (ys == eia_pkg::Y_CONST) &&
                        (ci > 6'(3 * eia_pkg::PASS_K_MAX));
              if (go && !ill_nxt) begin
                rf_nxt[ctx_r][instr_i[eia_pkg::DEST_BIT]
                              ? eia_pkg::RF_AF : eia_pkg::RF_AR] = yv;
                flg_nxt = {2'b00, yv[15], yv == 16'h0000};
              end
            end
            eia_pkg::EIA_MULTI: begin
              // constants need the cond/const fields the transfers use
              if (ys == eia_pkg::Y_CONST || fn > eia_pkg::F_XOR) begin
                ill_nxt = 1'b1;
              end else begin
                rf_nxt[ctx_r][instr_i[eia_pkg::DEST_BIT]
                              ? eia_pkg::RF_AF : eia_pkg::RF_AR] = res;
                flg_nxt = {fr[16], fr[17], res[15], res == 16'h0000};
                if (instr_i[eia_pkg::MF_RD0_BIT])
                  rf_nxt[ctx_r][eia_pkg::RF_AX0] = mem_rd0_i;
                if (instr_i[eia_pkg::MF_RD1_BIT])
                  rf_nxt[ctx_r][eia_pkg::RF_AY0] = mem_rd1_i;
                wr_nxt = instr_i[eia_pkg::MF_WR_BIT];
                wd_nxt = rf_r[ctx_r][eia_pkg::RF_AR]; // old value out
              end
            end
            eia_pkg::EIA_LOAD: begin
              if (xs > eia_pkg::RF_AF) ill_nxt = 1'b1;
              else rf_nxt[ctx_r][xs] = mem_rd0_i;
            end
            eia_pkg::EIA_ENA:  gie_nxt = 1'b1;
            eia_pkg::EIA_DIS:  gie_nxt = 1'b0;
            eia_pkg::EIA_MASK: mask_nxt = mem_rd0_i[NIRQ-1:0];
            eia_pkg::EIA_CTX:  ctx_nxt = !ctx_r;
            eia_pkg::EIA_BR:   br_nxt = go;
            eia_pkg::EIA_IDLE: begin
              if (dc > 3'(eia_pkg::DIV_CODE_MAX)) ill_nxt = 1'b1;
              else begin
                st_nxt = eia_pkg::ST_IDLE;
                cnt_nxt = 7'h00;
                lim_nxt = (dc == 3'h0) ? 7'h00 :
                  7'((8'h01 << (eia_pkg::DIV_BASE_LOG2 + dc - 1)) - 1);
              end
            end
            eia_pkg::EIA_NOP: ;
            default: ill_nxt = 1'b1;
          endcase
        end
      end
      eia_pkg::ST_IDLE: begin
        // interrupts are looked at only in a tick cycle, so a slowed
        // wait answers within one divide period
        if (cke_r && |svc) begin
          st_nxt = eia_pkg::ST_RUN;
          take_nxt = 1'b1;
          sel_nxt = pick;
        end else if (cnt_r == lim_r) begin
          cnt_nxt = 7'h00;
          cke_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 7'h01;
          cke_nxt = 1'b0;
        end
      end
      default: st_nxt = eia_pkg::ST_RUN;
    endcase
    ar_nxt = rf_nxt[ctx_nxt][eia_pkg::RF_AR];
    af_nxt = rf_nxt[ctx_nxt][eia_pkg::RF_AF];
  end

  // registers; reset ignores ce_i, else ce_i low freezes everything
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int b = 0; b < 2; b++)
        for (int r = 0; r < eia_pkg::RF_N; r++)
          rf_r[b][r] <= eia_pkg::RF_RST;
      flg_r  <= eia_pkg::FLG_RST;
      ctx_r  <= eia_pkg::CTX_RST;
      gie_r  <= eia_pkg::GIE_RST;
      mask_r <= '0;
      st_r   <= eia_pkg::ST_RUN;
      cnt_r  <= 7'h00;
      lim_r  <= 7'h00;
      br_r   <= 1'b0;
      wr_r   <= 1'b0;
      wd_r   <= 16'h0000;
      ill_r  <= 1'b0;
      take_r <= 1'b0;
      sel_r  <= '0;
      cke_r  <= 1'b1;
      ab_r   <= 1'b0;
      ar_r   <= eia_pkg::RF_RST;
      af_r   <= eia_pkg::RF_RST;
    end else if (ce_i) begin
      rf_r   <= rf_nxt;
      flg_r  <= flg_nxt;
      ctx_r  <= ctx_nxt;
      gie_r  <= gie_nxt;
      mask_r <= mask_nxt;
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      lim_r  <= lim_nxt;
      br_r   <= br_nxt;
      wr_r   <= wr_nxt;
      wd_r   <= wd_nxt;
      ill_r  <= ill_nxt;
      take_r <= take_nxt;
      sel_r  <= sel_nxt;
      cke_r  <= cke_nxt;
      ab_r   <= ab_nxt;
      ar_r   <= ar_nxt;
      af_r   <= af_nxt;
    end
  end

  // outputs straight from flops
  assign alu_result_reg_o     = ar_r;
  assign alu_feedback_reg_o   = af_r;
  assign flags_o              = flg_r;
  assign branch_o             = br_r;
  assign mem_wr_o             = wr_r;
  assign mem_wr_data_o        = wd_r;
  assign illegal_o            = ill_r;
  assign irq_take_o           = take_r;
  assign irq_sel_o            = sel_r;
  assign idle_o               = (st_r == eia_pkg::ST_IDLE);
  assign core_clk_en_o        = cke_r;
  assign ctx_o                = ctx_r;
  assign gie_o                = gie_r;
  assign interrupt_mask_reg_o = mask_r;
  assign autobuf_grant_o      = ab_r;

endmodule // eia_extended_instruction_alu

/* design/eia_pkg.sv */
/*
  constants, field layout and types for the extended-instruction alu.
  assumes the decoded instruction arrives as one word per core cycle.
*/
package eia_pkg;
  // instruction word layout
  localparam int unsigned IW         = 24;
  localparam int unsigned OP_LSB     = 20;
  localparam int unsigned COND_LSB   = 16;
  localparam int unsigned FUNC_LSB   = 12;
  localparam int unsigned XOP_LSB    = 9;
  localparam int unsigned YOP_LSB    = 7;
  localparam int unsigned CONST_LSB  = 1;
  localparam int unsigned DEST_BIT   = 0;
  localparam int unsigned MF_RD0_BIT = 19;
  localparam int unsigned MF_RD1_BIT = 18;
  localparam int unsigned MF_WR_BIT  = 17;
  localparam int unsigned DIV_LSB    = 0;

  typedef enum logic [3:0] {
    EIA_NOP, EIA_ALU, EIA_PASS, EIA_MULTI, EIA_LOAD,
    EIA_ENA, EIA_DIS, EIA_IDLE, EIA_CTX, EIA_MASK, EIA_BR
  } eia_op_t;

  typedef enum logic [3:0] {
    F_ADD, F_ADDC, F_XSUBY, F_XSUBYB, F_YSUBX, F_YSUBXB,
    F_AND, F_OR, F_XOR
  } eia_func_t;

  typedef enum logic {ST_RUN, ST_IDLE} eia_state_t;

  // register file slots, also the load destination codes
  localparam logic [2:0] RF_AX0 = 3'h0;
  localparam logic [2:0] RF_AX1 = 3'h1;
  localparam logic [2:0] RF_AY0 = 3'h2;
  localparam logic [2:0] RF_AY1 = 3'h3;
  localparam logic [2:0] RF_AR  = 3'h4;
  localparam logic [2:0] RF_AF  = 3'h5;
  localparam int unsigned RF_N  = 6;

  // x operand codes
  localparam logic [2:0] X_AX0 = 3'h0;
  localparam logic [2:0] X_AX1 = 3'h1;
  localparam logic [2:0] X_AR  = 3'h2;
  localparam logic [2:0] X_MR0 = 3'h3;
  localparam logic [2:0] X_MR1 = 3'h4;
  localparam logic [2:0] X_MR2 = 3'h5;
  localparam logic [2:0] X_SR0 = 3'h6;
  localparam logic [2:0] X_SR1 = 3'h7;

  // y operand codes
  localparam logic [1:0] Y_AY0   = 2'h0;
  localparam logic [1:0] Y_AY1   = 2'h1;
  localparam logic [1:0] Y_AF    = 2'h2;
  localparam logic [1:0] Y_CONST = 2'h3;

  // flag positions
  localparam int unsigned FL_AZ = 0;
  localparam int unsigned FL_AN = 1;
  localparam int unsigned FL_AC = 2;
  localparam int unsigned FL_AV = 3;

  // slow wait divide: code 1..4 gives 16 << (code-1)
  localparam int unsigned DIV_BASE_LOG2 = 4;
  localparam int unsigned DIV_CODE_MAX  = 4;
  localparam int unsigned PASS_K_MAX    = 15;

  // values after reset
  localparam logic       GIE_RST  = 1'b1;
  localparam logic       CTX_RST  = 1'b0;
  localparam logic [3:0] FLG_RST  = 4'h0;
  localparam logic [15:0] RF_RST  = 16'h0000;
endpackage

/* sim/eia_alu_checker.sv */
/*
  concurrent checks on the top ports of the extended-instruction alu.
  assumes one clock, synchronous active-high reset, one word per cycle.
*/
`timescale 1ns/100ps
module eia_alu_checker #(
  parameter int unsigned NIRQ = 8
) (
  // clock and reset
  input wire logic            mclk_i,
  input wire logic            reset_i,
  // instruction and requests
  input wire logic            ce_i,
  input wire logic            op_valid_i,
  input wire logic [23:0]     instr_i,
  input wire logic [NIRQ-1:0] irq_req_i,
  input wire logic            autobuf_req_i,
  // design outputs
  input wire logic [15:0]     alu_result_reg_o,
  input wire logic            mem_wr_o,
  input wire logic [15:0]     mem_wr_data_o,
  input wire logic            illegal_o,
  input wire logic            irq_take_o,
  input wire logic [NIRQ-1:0] irq_sel_o,
  input wire logic            idle_o,
  input wire logic            core_clk_en_o,
  input wire logic            ctx_o,
  input wire logic            gie_o,
  input wire logic [NIRQ-1:0] interrupt_mask_reg_o,
  input wire logic            autobuf_grant_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // decode helpers; want is the highest pending enabled request
  logic [3:0]      op_w;
  logic            tk;
  logic            svc;
  logic [NIRQ-1:0] want;
  assign op_w = instr_i[23:20];
  assign tk   = ce_i && op_valid_i && !idle_o;
  assign svc  = gie_o && |(irq_req_i & interrupt_mask_reg_o);
  always_comb begin
    want = '0;
    for (int i = 0; i < NIRQ; i++) begin
      if (irq_req_i[i] && interrupt_mask_reg_o[i]) begin
        want    = '0;
        want[i] = 1'b1;
      end
    end
  end

  // slow wait steps: divide by 16 gives fifteen quiet cycles
  sequence s_idle16;
    tk && op_w == eia_pkg::EIA_IDLE && instr_i[2:0] == 3'h1;
  endsequence
  sequence s_gap15;
    !core_clk_en_o [*8] ##1 !core_clk_en_o [*7];
  endsequence

  AST_RESET_STATE: assert property (disable iff (1'b0)
    $fell(reset_i) |-> gie_o && !ctx_o && !idle_o && core_clk_en_o)
    else $error("state after reset wrong");
  AST_SLOW16: assert property (
    s_idle16 ##1 (idle_o && core_clk_en_o && !svc) |=> s_gap15 ##1
    core_clk_en_o) else $error("slow wait tick spacing wrong");
  AST_IDLE_ENTER: assert property (
    tk && op_w == eia_pkg::EIA_IDLE && instr_i[2:0] <= 3'h4 |=> idle_o)
    else $error("wait not entered");
  AST_WAKE: assert property (
    idle_o && core_clk_en_o && svc |=> !idle_o && irq_take_o)
    else $error("no wake at tick");
  AST_WAKE_BOUND: assert property (
    idle_o && svc |-> ##[1:129] !idle_o) else $error("wake too slow");
  AST_DIS: assert property (
    tk && op_w == eia_pkg::EIA_DIS |=> !gie_o &&
    $stable(interrupt_mask_reg_o)) else $error("disable wrong");
  AST_ENA: assert property (
    tk && op_w == eia_pkg::EIA_ENA |=> gie_o) else $error("enable wrong");
  AST_BLOCKED: assert property (
    ce_i && !gie_o |=> !irq_take_o) else $error("take while disabled");
  AST_TAKE: assert property (
    ce_i && !idle_o && svc |=> irq_take_o && irq_sel_o == $past(want))
    else $error("interrupt not taken");
  AST_AUTOBUF: assert property (
    ce_i |=> autobuf_grant_o == $past(autobuf_req_i))
    else $error("autobuffer grant wrong");
  AST_MF_WRITE: assert property (
    tk && op_w == eia_pkg::EIA_MULTI && instr_i[17] &&
    instr_i[8:7] != 2'h3 && instr_i[15:12] <= 4'h8
    |=> mem_wr_o && mem_wr_data_o == $past(alu_result_reg_o))
    else $error("multifunction write wrong");
  AST_MF_CONST: assert property (
    tk && op_w == eia_pkg::EIA_MULTI && instr_i[8:7] == 2'h3
    |=> illegal_o && !mem_wr_o) else $error("constant in multi accepted");
  AST_CTX: assert property (
    tk && op_w == eia_pkg::EIA_CTX |=> ctx_o != $past(ctx_o))
    else $error("bank not switched");
endmodule // eia_alu_checker

bind eia_extended_instruction_alu eia_alu_checker #(.NIRQ(NIRQ)) u_chk (.*);

/* sim/eia_extended_instruction_alu_tb.sv */
/*
  self-checking bench for the extended-instruction alu.
  assumes the checker is bound to the top; ce_i is held high.
*/
`timescale 1ns/100ps
module eia_extended_instruction_alu_tb;
  localparam int unsigned NIRQ = 8;
  // design inputs
  logic            mclk_i = 1'b0;
  logic            reset_i = 1'b1;
  logic            ce_i = 1'b1;
  logic            op_valid_i = 1'b0;
  logic            mac_ovf_i = 1'b0;
  logic            cntr_expired_i = 1'b0;
  logic            autobuf_req_i = 1'b0;
  logic [23:0]     instr_i = 24'h0;
  logic [15:0]     mem_rd0_i = 16'h0;
  logic [15:0]     mem_rd1_i = 16'h0;
  logic [15:0]     xr [3:7] = '{default: 16'h0};
  logic [NIRQ-1:0] irq_req_i = '0;
  // design outputs
  logic [15:0]     alu_result_reg_o, alu_feedback_reg_o, mem_wr_data_o;
  logic [3:0]      flags_o;
  logic            branch_o, mem_wr_o, illegal_o, irq_take_o, idle_o;
  logic            core_clk_en_o, ctx_o, gie_o, autobuf_grant_o;
  logic [NIRQ-1:0] irq_sel_o, interrupt_mask_reg_o;
  // reference model state
  logic [15:0]     rf [2][6] = '{default: 16'h0};
  logic [3:0]      ops [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'ha};
  logic [3:0]      fl = 4'h0, op, c, f;
  logic [2:0]      x;
  logic [1:0]      y;
  logic [5:0]      k;
  logic            b = 1'b0, d, t, ill, wr, ab;
  logic [15:0]     xv, yv, wd;
  logic [19:0]     r;
  int              n, w, ones, miscompares = 0, checked = 0, cyc = 0;

  eia_extended_instruction_alu #(.NIRQ(NIRQ)) DUT (.*,
    .mac_result_low_i(xr[3]), .mac_result_mid_i(xr[4]),
    .mac_result_high_i(xr[5]), .shifter_result_low_i(xr[6]),
    .shifter_result_high_i(xr[7]));

  // clock and hang guard
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // one word taken at the next edge, answer read at the falling edge after
  task automatic ex(input logic [23:0] iw);
    instr_i = iw;
    op_valid_i = 1'b1;
    @(negedge mclk_i);
  endtask

  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // condition pairs, odd code inverts, code 15 always true
  function automatic logic cnd(input logic [3:0] cc, fv, input logic mv, ce);
    logic [7:0] s;
    s = {!ce, mv, fv[1], fv[2], fv[3], fv[1] ^ fv[3],
         !((fv[1] ^ fv[3]) || fv[0]), fv[0]};
    return cc == 4'hf ? 1'b1 : s[cc[3:1]] ^ cc[0];
  endfunction

  // returns {av, ac, an, az, result}; borrow forms use ac as carry in
  function automatic logic [19:0] alu(input logic [3:0] fn,
                                      input logic [15:0] xa, ya,
                                      input logic ci);
    logic [16:0] s;
    logic [15:0] a, bb;
    a = (fn == 4'h4 || fn == 4'h5) ? ya : xa;
    bb = (fn == 4'h4 || fn == 4'h5) ? ~xa :
         (fn == 4'h2 || fn == 4'h3) ? ~ya : ya;
    s = {1'b0, a} + {1'b0, bb} + {16'h0, fn[0] ? ci : fn != 4'h0};
    if (fn > 4'h5)
      s = {1'b0, fn == 4'h6 ? xa & ya : (fn == 4'h7 ? xa | ya : xa ^ ya)};
    return {fn < 4'h6 && a[15] == bb[15] && s[15] != a[15], s[16], s[15],
            s[15:0] == 16'h0, s[15:0]};
  endfunction

  function automatic logic [15:0] kc(input int i);
    if (i == 0) return 16'h0;
    if (i < 16) return 16'h1 << (i - 1);
    if (i == 16) return 16'h7fff;
    if (i < 32) return 16'h0 - (16'h1 << (i - 17)) - 16'h1;
    return 16'h8000;
  endfunction

  function automatic logic [15:0] kp(input int i);
    if (i == 0) return 16'h0;
    return (16'h1 << ((i - 1) / 3 + 1)) - 16'h1 + 16'((i - 1) % 3);
  endfunction

  // main sequence
  initial begin
    void'($urandom(32'h7139));
    repeat (10) @(negedge mclk_i);
    reset_i = 1'b0;
    chk(gie_o, 1'b1);
    chk({ctx_o, idle_o, core_clk_en_o, flags_o}, 7'h10);
    $display("test reset done");
    mem_rd0_i = 16'h0005;
    ex({eia_pkg::EIA_MASK, 20'hf0000});
    chk(interrupt_mask_reg_o, 8'h05);
    irq_req_i = 8'h04;
    ex(24'h0);
    chk({irq_take_o, irq_sel_o}, 9'h104);
    irq_req_i = '0;
    ex({eia_pkg::EIA_DIS, 20'hf0000});
    chk({gie_o, interrupt_mask_reg_o}, 9'h005);
    $display("test interrupt gate done");
    // random traffic while interrupts are globally off
    for (int i = 0; i < 300; i++) begin
      op = ops[$urandom % 6];
      c = (op == 4'h4 || op == 4'h8) ? 4'hf : 4'($urandom);
      f = 4'($urandom % 9);
      x = 3'($urandom % (op == eia_pkg::EIA_LOAD ? 6 : 8));
      y = 2'($urandom);
      k = 6'($urandom % (op == eia_pkg::EIA_PASS ? 46 : 33));
      d = 1'($urandom);
      if (op == eia_pkg::EIA_MULTI && y == 2'h3 && i % 4 != 0) y = 2'h0;
      mem_rd0_i = 16'($urandom);
      mem_rd1_i = 16'($urandom);
      foreach (xr[j]) xr[j] = 16'($urandom);
      mac_ovf_i = 1'($urandom);
      cntr_expired_i = 1'($urandom);
      irq_req_i = NIRQ'($urandom);
      autobuf_req_i = 1'($urandom);
      ab = autobuf_req_i;
      xv = x < 2 ? rf[b][x] : (x == 2 ? rf[b][4] : xr[x]);
      yv = y < 2 ? rf[b][2+y] : (y == 2 ? rf[b][5] :
           (op == eia_pkg::EIA_PASS ? kp(k) : kc(k)));
      ill = op == eia_pkg::EIA_MULTI && y == 2'h3;
      t = op == eia_pkg::EIA_MULTI ? !ill
                                   : cnd(c, fl, mac_ovf_i, cntr_expired_i);
      wr = op == eia_pkg::EIA_MULTI && !ill && c[1];
      wd = rf[b][4];
      ex({op, c, f, x, y, k, d});
      if (t && (op == eia_pkg::EIA_ALU || op == eia_pkg::EIA_MULTI)) begin
        r = alu(f, xv, yv, fl[2]);
        fl = r[19:16];
        rf[b][4+d] = r[15:0];
      end
      if (t && op == eia_pkg::EIA_PASS) begin
        fl = {2'b00, yv[15], yv == 16'h0};
        rf[b][4+d] = yv;
      end
      if (op == eia_pkg::EIA_LOAD) rf[b][x] = mem_rd0_i;
      if (t && op == eia_pkg::EIA_MULTI && c[3]) rf[b][0] = mem_rd0_i;
      if (t && op == eia_pkg::EIA_MULTI && c[2]) rf[b][2] = mem_rd1_i;
      if (op == eia_pkg::EIA_CTX) b = !b;
      chk(alu_result_reg_o, rf[b][4]);
      chk(alu_feedback_reg_o, rf[b][5]);
      chk(flags_o, fl);
      chk(ctx_o, b);
      chk(illegal_o, ill);
      chk(branch_o, op == eia_pkg::EIA_BR && t);
      chk(mem_wr_o, wr);
      if (wr) chk(mem_wr_data_o, wd);
      chk(autobuf_grant_o, ab);
      chk(irq_take_o, 1'b0);
    end
    $display("test random traffic done");
    // refused encodings leave the result registers alone
    ex({eia_pkg::EIA_ALU, 4'hf, 4'h9, 12'h000});
    chk({illegal_o, alu_result_reg_o}, {1'b1, rf[b][4]});
    ex({eia_pkg::EIA_ALU, 4'hf, 4'h0, 3'h0, 2'h3, 6'h21, 1'b0});
    chk({illegal_o, alu_result_reg_o}, {1'b1, rf[b][4]});
    ex({eia_pkg::EIA_PASS, 4'hf, 4'h0, 3'h0, 2'h3, 6'h2e, 1'b0});
    chk({illegal_o, alu_result_reg_o}, {1'b1, rf[b][4]});
    chk(flags_o, fl);
    $display("test refused words done");
    irq_req_i = 8'h05;
    ex({eia_pkg::EIA_ENA, 20'hf0000});
    chk({gie_o, irq_take_o}, 2'h2);
    ex(24'h0);
    chk({irq_take_o, irq_sel_o}, 9'h104);
    irq_req_i = '0;
    // plain and slowed waits; a 2n window always holds two ticks
    for (int cd = 0; cd < 6; cd++) begin
      n = cd == 0 ? 1 : 16 << (cd - 1);
      ex({eia_pkg::EIA_IDLE, 20'hf0000} | 24'(cd));
      instr_i = 24'h0;
      if (cd == 5) begin
        chk({illegal_o, idle_o}, 2'h2);
      end else begin
        ones = 0;
        repeat (2 * n) begin
          ones += core_clk_en_o;
          @(negedge mclk_i);
        end
        chk(ones, 2);
        chk(idle_o, 1'b1);
        // step off the tick so the wake waits a whole divide period
        @(negedge mclk_i);
        irq_req_i = 8'h01;
        w = 0;
        while (irq_take_o !== 1'b1 && w <= n) begin
          @(negedge mclk_i);
          w++;
        end
        irq_req_i = '0;
        chk(w <= n, 1'b1);
        chk(idle_o, 1'b0);
      end
    end
    $display("test slow wait done");
    finish_test();
  end
endmodule // eia_extended_instruction_alu_tb
